// *** logic/cra_buf2.sv ***
`timescale 1ns/100ps
module cra_buf2 #(
  parameter int W = 33
) (
  input  wire logic         clock,  // 200 MHz
  input  wire logic         rst,    // sync, active high
  input  wire logic         in_valid,  // writer has word
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_word,   // word in
  output logic              out_valid, // word available
  input  wire logic         out_ready, // reader takes word
  output logic [W-1:0]      out_word   // oldest word
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } cra_buf_s;

  cra_buf_s r;
  cra_buf_s next_r;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign in_ready  = (r.cnt != 2'h2);
  assign out_valid = (r.cnt != 2'h0);
  assign out_word  = r.mem[r.rp];

  // pointer and count update
  always_comb begin
    logic push;
    logic pop;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_word;
      next_r.wp        = ~r.wp;
    end
    if (pop) begin
      next_r.rp = ~r.rp;
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 2'h1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // cra_buf2

// *** logic/cra_engine.sv ***
`timescale 1ns/100ps
module cra_engine (
  input  wire logic                 clock,       // 200 MHz
  input  wire logic                 rst,         // sync, active high
  input  wire cra_pkg::cra_target_e target,      // kind of register bank addressed
  input  wire logic                 in_valid,    // request token present
  output logic                      in_ready,    // engine takes token
  input  wire logic                 in_ctrl,     // token is a control token
  input  wire logic [7:0]           in_data,     // token value
  output logic                      out_valid,   // reply token present
  input  wire logic                 out_ready,   // receiver takes reply token
  output logic                      out_ctrl,    // reply token is control
  output logic [7:0]                out_data,    // reply token value
  output logic [23:0]               out_dest,    // reply channel-end
  output logic                      reg_req,     // access request, held till ack
  output logic                      reg_write,   // access is a write
  output cra_pkg::cra_target_e      reg_target,  // bank of the access
  output logic [15:0]               reg_addr,    // register number
  output logic [31:0]               reg_wdata,   // write data
  output logic [7:0]                reg_size,    // peripheral byte count
  input  wire logic                 reg_ack,     // access done, one pulse
  input  wire logic                 reg_ok,      // access succeeded
  input  wire logic [31:0]          reg_rdata    // read data, low bytes used
);
  import cra_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_REPLY   = 4'h1,
    S_REG     = 4'h2,
    S_SIZE    = 4'h3,
    S_DATA    = 4'h4,
    S_END     = 4'h5,
    S_ACCESS  = 4'h6,
    S_HEAD    = 4'h7,
    S_BYTES   = 4'h8,
    S_TAIL    = 4'h9,
    S_DISCARD = 4'hA
  } cra_state_e;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ  = 2'h1,
    OP_PREAD = 2'h2
  } cra_op_e;

  typedef struct packed {
    cra_state_e  st;
    cra_op_e     op;
    cra_target_e tgt;
    logic        bad;    // opcode does not suit the bank
    logic [2:0]  cnt;
    logic [23:0] reply;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [7:0]  size;
    logic [31:0] rdata;
    logic        ok;
    logic        req;
  } cra_eng_s;

  cra_eng_s r;
  cra_eng_s next_r;

  logic              take;
  logic              push_valid;
  logic              push_ready;
  logic              push_ctrl;
  logic [7:0]        push_data;
  logic [OUT_W-1:0]  pop_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // state after a control token where a data byte was due
  function automatic cra_state_e cra_abort(input logic [7:0] tok);
    cra_abort = (tok == TOK_END) ? S_IDLE : S_DISCARD;
  endfunction

  // number of data bytes a successful read returns
  function automatic logic [2:0] cra_nbytes(input cra_op_e op, input logic [7:0] sz);
    cra_nbytes = (op == OP_READ) ? 3'h4 : sz[2:0];
  endfunction

  // write whose reply field asks for silence
  function automatic logic cra_muted(input cra_op_e op, input logic [23:0] rep);
    cra_muted = (op == OP_WRITE) && (rep[7:0] == NOREPLY_LOW);
  endfunction

  // ----------------------------------------------------------------
  // token handshake and reply source
  // ----------------------------------------------------------------
  assign in_ready = (r.st == S_IDLE) || (r.st == S_REPLY) || (r.st == S_REG) ||
                    (r.st == S_SIZE) || (r.st == S_DATA) || (r.st == S_END) ||
                    (r.st == S_DISCARD);
  assign take     = in_valid && in_ready;

  // reply tokens only leave after the closing token
  always_comb begin
    push_valid = 1'b0;
    push_ctrl  = 1'b1;
    push_data  = TOK_END;
    unique case (r.st)
      S_HEAD: begin
        push_valid = 1'b1;
        push_data  = r.ok ? TOK_ACK : TOK_NAK;
      end
      S_BYTES: begin
        push_valid = 1'b1;
        push_ctrl  = 1'b0;
        push_data  = r.rdata[{r.cnt[1:0], 3'h0} +: 8];
      end
      S_TAIL: begin
        push_valid = 1'b1;
      end
      default: begin
        push_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // request parser and access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    unique case (r.st)
      S_IDLE: begin
        if (take && in_ctrl) begin
          next_r.cnt = 3'h0;
          next_r.tgt = target;
          next_r.st  = S_REPLY;
          if (in_data == TOK_WRITE) begin
            next_r.op  = OP_WRITE;
            next_r.bad = (target == TGT_PERIPH);
          end else if (in_data == TOK_READ) begin
            next_r.op  = OP_READ;
            next_r.bad = (target == TGT_PERIPH);
          end else if (in_data == TOK_PREAD) begin
            next_r.op  = OP_PREAD;
            next_r.bad = (target != TGT_PERIPH);
          end else begin
            next_r.st = cra_abort(in_data);
          end
        end
      end
      S_REPLY: begin
        if (take) begin
          if (in_ctrl) begin
            next_r.st = cra_abort(in_data);
          end else begin
            next_r.reply = {r.reply[15:0], in_data};
            next_r.cnt   = r.cnt + 3'h1;
            if (r.cnt == REPLY_LAST) begin
              next_r.cnt = 3'h0;
              next_r.st  = S_REG;
            end
          end
        end
      end
      S_REG: begin
        if (take) begin
          if (in_ctrl) begin
            next_r.st = cra_abort(in_data);
          end else if (r.op == OP_PREAD) begin
            next_r.addr = {8'h00, in_data};
            next_r.st   = S_SIZE;
          end else begin
            next_r.addr = {r.addr[7:0], in_data};
            next_r.cnt  = r.cnt + 3'h1;
            if (r.cnt == REG_LAST_CFG) begin
              next_r.cnt = 3'h0;
              next_r.st  = (r.op == OP_WRITE) ? S_DATA : S_END;
            end
          end
        end
      end
      S_SIZE: begin
        if (take) begin
          if (in_ctrl) begin
            next_r.st = cra_abort(in_data);
          end else begin
            next_r.size = in_data;
            next_r.st   = S_END;
          end
        end
      end
      S_DATA: begin
        if (take) begin
          if (in_ctrl) begin
            next_r.st = cra_abort(in_data);
          end else begin
            next_r.wdata = {r.wdata[23:0], in_data};
            next_r.cnt   = r.cnt + 3'h1;
            if (r.cnt == DATA_LAST) begin
              next_r.cnt = 3'h0;
              next_r.st  = S_END;
            end
          end
        end
      end
      // closing token: reject, or start the access
      S_END: begin
        if (take) begin
          if (in_ctrl && (in_data == TOK_END)) begin
            if (r.bad || ((r.op == OP_PREAD) && (r.size > PERIPH_MAX))) begin
              next_r.ok = 1'b0;
              next_r.st = S_HEAD;
            end else begin
              next_r.req = 1'b1;
              next_r.st  = S_ACCESS;
            end
            if (cra_muted(r.op, r.reply) && r.bad) begin
              next_r.st = S_IDLE;
            end
          end else begin
            next_r.st = in_ctrl ? cra_abort(in_data) : S_DISCARD;
          end
        end
      end
      // swallow tokens up to the closing token
      S_DISCARD: begin
        if (take && in_ctrl && (in_data == TOK_END)) begin
          next_r.st = S_IDLE;
        end
      end
      // hold the request until the bank answers
      S_ACCESS: begin
        if (reg_ack) begin
          next_r.req   = 1'b0;
          next_r.ok    = reg_ok;
          next_r.rdata = reg_rdata;
          if (cra_muted(r.op, r.reply)) begin
            next_r.st = S_IDLE;
          end else begin
            next_r.st = S_HEAD;
          end
        end
      end
      S_HEAD: begin
        if (push_ready) begin
          if (r.ok && (r.op != OP_WRITE) && (cra_nbytes(r.op, r.size) != 3'h0)) begin
            next_r.cnt = cra_nbytes(r.op, r.size) - 3'h1;
            next_r.st  = S_BYTES;
          end else begin
            next_r.st = S_TAIL;
          end
        end
      end
      S_BYTES: begin
        if (push_ready) begin
          next_r.cnt = r.cnt - 3'h1;
          if (r.cnt == 3'h0) begin
            next_r.st = S_TAIL;
          end
        end
      end
      S_TAIL: begin
        if (push_ready) begin
          next_r.st = S_IDLE;
        end
      end
      default: begin
        next_r.st  = S_IDLE;
        next_r.req = 1'b0;
      end
    endcase
  end

  // state register, cleared by sync reset
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // register access port
  // ----------------------------------------------------------------
  assign reg_req    = r.req;
  assign reg_write  = (r.op == OP_WRITE);
  assign reg_target = r.tgt;
  assign reg_addr   = r.addr;
  assign reg_wdata  = r.wdata;
  assign reg_size   = r.size;

  // ----------------------------------------------------------------
  // reply buffer, destination travels with each token
  // ----------------------------------------------------------------
  cra_buf2 #(
    .W (OUT_W)
  ) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_word   ({r.reply, push_ctrl, push_data}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_word  (pop_word)
  );

  // split the buffered word back into fields
  assign out_dest = pop_word[32:9];
  assign out_ctrl = pop_word[8];
  assign out_data = pop_word[7:0];
endmodule // cra_engine

// *** logic/cra_pkg.sv ***
package cra_pkg;

  // ----------------------------------------------------------------
  // control tokens
  // ----------------------------------------------------------------
  localparam logic [7:0] TOK_WRITE  = 8'hC0;  // 192
  localparam logic [7:0] TOK_READ   = 8'hC1;  // 193
  localparam logic [7:0] TOK_PREAD  = 8'h25;  // 37
  localparam logic [7:0] TOK_END    = 8'h01;
  localparam logic [7:0] TOK_ACK    = 8'h03;
  localparam logic [7:0] TOK_NAK    = 8'h04;

  // ----------------------------------------------------------------
  // field sizes and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] REPLY_LAST    = 3'h2;   // 3 reply bytes
  localparam logic [2:0] REG_LAST_CFG  = 3'h1;   // 2 register bytes
  localparam logic [2:0] DATA_LAST     = 3'h3;   // 4 data bytes
  localparam logic [7:0] PERIPH_MAX    = 8'h04;  // most bytes per peripheral read
  localparam logic [7:0] NOREPLY_LOW   = 8'hFF;  // reply low byte that mutes a write
  localparam logic [7:0] PS_RES_TYPE   = 8'h0C;  // status resource type
  localparam int         PS_RES_SHIFT  = 8;
  localparam logic [15:0] TILE_DEST_LOW = 16'hC20C;
  localparam logic [15:0] NODE_DEST_LOW = 16'hC30C;
  localparam logic [7:0]  PER_DEST_LOW  = 8'h02;
  localparam int          OUT_W         = 33;    // dest 24 + ctrl 1 + data 8

  typedef enum logic [1:0] {
    TGT_TILE   = 2'h0,
    TGT_NODE   = 2'h1,
    TGT_PERIPH = 2'h2
  } cra_target_e;

  // processor status resource id, formed by the caller
  function automatic logic [31:0] cra_ps_resource(input logic [23:0] regnum);
    cra_ps_resource = (32'(regnum) << PS_RES_SHIFT) | {24'h0, PS_RES_TYPE};
  endfunction

endpackage

// *** test/config_register_message_access_test.sv ***
`timescale 1ns/100ps
module config_register_message_access_test;
  import cra_pkg::*;
  logic        clock = 1'b0;  // 200 MHz
  logic        rst, in_valid, in_ready, in_ctrl, out_valid, out_ready, out_ctrl, slow;
  logic        reg_req, reg_write, reg_ack, reg_ok;
  logic [7:0]  in_data, out_data, reg_size;
  logic [15:0] reg_addr;
  logic [23:0] out_dest;
  logic [31:0] reg_wdata, reg_rdata;
  cra_target_e target, reg_target;
  int          fail_count = 0;
  int          num_checks = 0;
  // free-running clock
  always #2.5 clock = ~clock;
  cra_engine i_dut (
    .clock, .rst, .target, .in_valid, .in_ready, .in_ctrl, .in_data, .out_valid,
    .out_ready, .out_ctrl, .out_data, .out_dest, .reg_req, .reg_write, .reg_target,
    .reg_addr, .reg_wdata, .reg_size, .reg_ack, .reg_ok, .reg_rdata
  );
  cra_regs_model i_regs (
    .clock, .rst, .slow, .reg_req, .reg_write, .reg_addr, .reg_wdata,
    .reg_ack, .reg_ok, .reg_rdata
  );
  task cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task send(input logic c, input logic [7:0] d);
    in_valid = 1'b1;
    in_ctrl = c;
    in_data = d;
    do @(posedge clock); while (in_ready !== 1'b1);
    #1;
  endtask
  task sendn(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--) send(1'b0, v[8*i+:8]);
  endtask
  task request(input logic [7:0] op, input logic [23:0] rep, input logic [15:0] ra,
               input logic [31:0] wd);
    @(posedge clock);
    #1;
    send(1'b1, op);
    sendn(3, {8'h00, rep});
    sendn(2, {16'h0, ra});
    if (op == TOK_WRITE) sendn(4, wd);
    send(1'b1, TOK_END);
    in_valid = 1'b0;
  endtask
  task take(input logic c, input logic [7:0] d, input logic [23:0] dst);
    out_ready = 1'b1;
    do @(posedge clock); while (out_valid !== 1'b1);
    cmp("reply", {7'h0, c, d, dst}, {7'h0, out_ctrl, out_data, out_dest});
    #1;
  endtask
  task t_write;
    out_ready = 1'b0;
    target = TGT_TILE;
    request(TOK_WRITE, 24'h123456, 16'h0102, 32'hA1B2C3D4);
    take(1'b1, TOK_ACK, 24'h123456);
    take(1'b1, TOK_END, 24'h123456);
    cmp("addr", 40'h0102, {24'h0, i_regs.last_addr});
    cmp("wdata", 40'hA1B2C3D4, {8'h0, i_regs.word});
    cmp("ps_res", 40'h050C, {8'h0, cra_ps_resource(24'h05)});
    $display("test write done");
  endtask
  task t_read;
    out_ready = 1'b0;
    slow = 1'b1;
    target = TGT_NODE;
    request(TOK_READ, 24'hABCDEF, 16'h0304, 32'h0);
    repeat (15) @(posedge clock);
    #1;
    take(1'b1, TOK_ACK, 24'hABCDEF);
    for (int i = 3; i >= 0; i--) begin
      take(1'b0, 8'(32'hA2B6C0D0 >> (8 * i)), 24'hABCDEF);
    end
    take(1'b1, TOK_END, 24'hABCDEF);
    slow = 1'b0;
    $display("test read done");
  endtask
  task t_mute;
    target = TGT_TILE;
    request(TOK_WRITE, 24'h1234FF, 16'h0010, 32'h55AA55AA);
    out_ready = 1'b1;
    repeat (20) begin
      @(posedge clock);
      cmp("no_reply", 40'h0, {39'h0, out_valid});
    end
    cmp("wdata", 40'h55AA55AA, {8'h0, i_regs.word});
    #1;
    $display("test mute done");
  endtask
  task t_fail;
    logic [7:0] ops [2];
    ops = '{TOK_READ, TOK_WRITE};
    foreach (ops[k]) begin
      request(ops[k], 24'h000701, 16'h8000, 32'h0BADF00D);
      take(1'b1, TOK_NAK, 24'h000701);
      take(1'b1, TOK_END, 24'h000701);
    end
    $display("test fail done");
  endtask
  task t_periph;
    target = TGT_PERIPH;
    request(TOK_PREAD, 24'h0A0B0C, 16'h2103, 32'h0);
    take(1'b1, TOK_ACK, 24'h0A0B0C);
    for (int i = 2; i >= 0; i--) begin
      take(1'b0, 8'(32'h558B558B >> (8 * i)), 24'h0A0B0C);
    end
    take(1'b1, TOK_END, 24'h0A0B0C);
    cmp("p_size", 40'h03, {32'h0, reg_size});
    cmp("p_bank", {38'h0, TGT_PERIPH}, {38'h0, reg_target});
    cmp("p_addr", 40'h0021, {24'h0, i_regs.last_addr});
    request(TOK_PREAD, 24'h0A0B0C, 16'h2105, 32'h0);
    take(1'b1, TOK_NAK, 24'h0A0B0C);
    take(1'b1, TOK_END, 24'h0A0B0C);
    $display("test periph done");
  endtask
  task t_odd;
    target = TGT_TILE;
    request(TOK_PREAD, 24'h00A0B1, 16'h0102, 32'h0);
    take(1'b1, TOK_NAK, 24'h00A0B1);
    take(1'b1, TOK_END, 24'h00A0B1);
    send(1'b1, 8'h50);
    send(1'b0, 8'h11);
    send(1'b1, TOK_END);
    send(1'b1, TOK_READ);
    send(1'b0, 8'h01);
    send(1'b1, TOK_END);
    in_valid = 1'b0;
    repeat (10) begin
      @(posedge clock);
      cmp("no_reply", 40'h0, {39'h0, out_valid});
    end
    #1;
    $display("test odd done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    in_valid = 1'b0;
    in_ctrl = 1'b0;
    in_data = 8'h00;
    out_ready = 1'b0;
    slow = 1'b0;
    target = TGT_TILE;
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    t_write;
    t_read;
    t_mute;
    t_fail;
    t_periph;
    t_odd;
    wrap_up;
  end
  // hang guard
  initial begin
    #20000;
    fail_count++;
    $display("watchdog ran out");
    wrap_up;
  end
endmodule // config_register_message_access_test

// *** test/cra_engine_asserts.sv ***
`timescale 1ns/100ps
module cra_engine_asserts (
  input logic                 clock,      // clock
  input logic                 rst,        // sync reset
  input logic                 in_valid,   // token offered
  input logic                 in_ready,   // token taken
  input logic                 in_ctrl,    // control flag
  input logic [7:0]           in_data,    // token value
  input logic                 out_valid,  // reply offered
  input logic                 out_ready,  // reply taken
  input logic                 out_ctrl,   // reply control flag
  input logic [7:0]           out_data,   // reply value
  input logic [23:0]          out_dest,   // reply channel-end
  input logic                 reg_req,    // access request
  input logic                 reg_write,  // write flag
  input cra_pkg::cra_target_e reg_target, // bank
  input logic [15:0]          reg_addr,   // register number
  input logic [31:0]          reg_wdata,  // write data
  input logic [7:0]           reg_size,   // byte count
  input logic                 reg_ack     // access done
);
  import cra_pkg::*;
  logic end_seen;  // closing token taken last edge
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // remembers a taken closing token
  always_ff @(posedge clock) begin
    end_seen <= !rst && in_valid && in_ready && in_ctrl && in_data == TOK_END;
  end
  // one reply token handed over
  sequence s_tok(logic [7:0] t);
    out_valid && out_ready && out_ctrl && out_data == t;
  endsequence
  chk_reset_idle: assert property ($fell(rst) |-> in_ready && !out_valid && !reg_req)
    else $error("outputs not idle after reset");
  chk_req_hold: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_addr)
    && $stable(reg_wdata) && $stable(reg_write) && $stable(reg_size))
    else $error("access changed before ack");
  chk_req_drop: assert property (reg_req && reg_ack |=> !reg_req)
    else $error("access request held after ack");
  chk_reply_hold: assert property (out_valid && !out_ready |=> out_valid
    && $stable(out_data) && $stable(out_ctrl) && $stable(out_dest))
    else $error("stalled reply token changed");
  chk_busy_ready: assert property (reg_req |-> !in_ready)
    else $error("token accepted during access");
  chk_req_after_end: assert property ($rose(reg_req) |-> end_seen)
    else $error("access started without closing token");
  chk_periph_fields: assert property (reg_req && reg_target == TGT_PERIPH
    |-> reg_addr[15:8] == 8'h00 && !reg_write)
    else $error("bad peripheral access fields");
  chk_periph_size: assert property (reg_req && reg_target == TGT_PERIPH
    |-> reg_size <= PERIPH_MAX)
    else $error("peripheral size above limit");
  chk_nak_end: assert property (s_tok(TOK_NAK) |=> ##[0:30] s_tok(TOK_END))
    else $error("failure reply not closed");
endmodule // cra_engine_asserts

bind cra_engine cra_engine_asserts i_chk (
  .clock, .rst, .in_valid, .in_ready, .in_ctrl, .in_data, .out_valid, .out_ready,
  .out_ctrl, .out_data, .out_dest, .reg_req, .reg_write, .reg_target, .reg_addr,
  .reg_wdata, .reg_size, .reg_ack
);

// *** test/cra_regs_model.sv ***
`timescale 1ns/100ps
module cra_regs_model (
  input  logic        clock,     // clock
  input  logic        rst,       // sync reset
  input  logic        slow,      // long access time
  input  logic        reg_req,   // access request
  input  logic        reg_write, // write flag
  input  logic [15:0] reg_addr,  // register number
  input  logic [31:0] reg_wdata, // write data
  output logic        reg_ack,   // done pulse
  output logic        reg_ok,    // success
  output logic [31:0] reg_rdata  // read data
);
  logic [3:0]  cnt;        // wait counter
  logic [31:0] word;       // last stored data
  logic [15:0] last_addr;  // register of last access
  // answer after a prompt or slow wait
  always_ff @(posedge clock) begin
    reg_ack <= 1'b0;
    if (rst) begin
      cnt <= 4'h0;
      word <= 32'h0;
      last_addr <= 16'h0;
    end else if (reg_req && !reg_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt == (slow ? 4'h6 : 4'h1)) begin
        reg_ack <= 1'b1;
        cnt <= 4'h0;
        last_addr <= reg_addr;
        if (reg_write && !reg_addr[15]) word <= reg_wdata;
      end
    end
  end
  // upper half of the map fails; data scrambled outside ack
  assign reg_ok = !reg_addr[15];
  assign reg_rdata = reg_ack ? word ^ {reg_addr, reg_addr} : ~word;
endmodule // cra_regs_model
